// file: hdl/access_snapshot.sv
// Captures the synchronous DRAM settings at the start of each access.
`timescale 1ns/1ps
module access_snapshot (
  input  wire logic                       sys_clk,      // System clock.
  input  wire logic                       reset,        // Async reset.
  input  wire logic                       capture,      // Access starts.
  input  wire logic                       sdram_select, // SDRAM chosen.
  input  wire logic [15:0]                ctrl_value,   // Control register.
  output      sdram_cfg_pkg::access_cfg_t snap          // Held settings.
);
  import sdram_cfg_pkg::*;

  access_cfg_t next_snap;

  // Forces every setting off unless synchronous DRAM is selected.
  always_comb begin
    next_snap = snap;
    if (capture) begin
      if (sdram_select) begin
        next_snap.mode_reg_set_enable   = ctrl_value[MODE_REG_SET_BIT];
        next_snap.clock_suspend_enable  = ctrl_value[CLOCK_SUSPEND_BIT];
        next_snap.write_precharge_delay = ctrl_value[WRITE_PRECHARGE_BIT];
      end else begin
        next_snap = '0;
      end
    end
  end

  // Holds the captured settings until the next access begins.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      snap <= '0;
    end else begin
      snap <= next_snap;
    end
  end

endmodule // access_snapshot

// file: hdl/sdram_cfg_pkg.sv
// Constants and types shared by the synchronous DRAM control register block.
// ============================================================================
// Function
// - The SDRAM settings act only while the DRAM type select bit is 1.
// - Bit 15 permits the SDRAM mode register set when 1, forbids it when 0.
// - Bits 14 to 12 always read as zero and ignore writes.
// - Bit 7 set turns on clock suspend and lengthens the read data cycle.
// - Bit 0 set adds one wait cycle between a write command and precharge.
package sdram_cfg_pkg;

  // ==========================================================================
  // Register map.
  localparam logic [7:0]  DRAM_ENABLE_OFF       = 8'h00;
  localparam logic [7:0]  SYNC_DRAM_CONTROL_OFF = 8'h04;
  localparam logic [7:0]  SDRAM_STATUS_OFF      = 8'h08;

  // Field positions.
  localparam int          DRAM_TYPE_SELECT_BIT  = 0;
  localparam int          MODE_REG_SET_BIT      = 15;
  localparam int          CLOCK_SUSPEND_BIT     = 7;
  localparam int          WRITE_PRECHARGE_BIT   = 0;

  // Values after reset and bit masks.
  localparam logic [15:0] DRAM_ENABLE_RESET     = 16'h0000;
  localparam logic [15:0] SYNC_DRAM_CTRL_RESET  = 16'h0000;
  localparam logic [15:0] DRAM_ENABLE_MASK      = 16'h0001;
  localparam logic [15:0] SYNC_DRAM_CTRL_MASK   = 16'h8D81;

  // SDRAM command codes: chip select, row strobe, column strobe, write enable.
  typedef enum logic [3:0] {
    CMD_NOP       = 4'h7,
    CMD_ACTIVATE  = 4'h3,
    CMD_READ      = 4'h5,
    CMD_WRITE     = 4'h4,
    CMD_PRECHARGE = 4'h2,
    CMD_MODE_SET  = 4'h0
  } sdram_cmd_code_t;

  // Command bundle that goes out to the memory pins.
  typedef struct packed {
    logic            cke;
    sdram_cmd_code_t code;
  } sdram_cmd_t;

  // Settings held for the length of one access.
  typedef struct packed {
    logic mode_reg_set_enable;
    logic clock_suspend_enable;
    logic write_precharge_delay;
  } access_cfg_t;

  localparam sdram_cmd_t  CMD_IDLE_BUS = '{cke: 1'b1, code: CMD_NOP};

endpackage

// file: hdl/sdram_ctrl_block.sv
// Register file and access sequencer for the synchronous DRAM interface.
`timescale 1ns/1ps
module sdram_ctrl_block (
  input  wire logic                      sys_clk,      // System clock.
  input  wire logic                      reset,        // Async reset.
  input  wire logic [7:0]                reg_addr,     // Register address.
  input  wire logic [15:0]               reg_wdata,    // Write data.
  input  wire logic                      reg_write,    // Write strobe.
  input  wire logic                      reg_read,     // Read strobe.
  output      logic [15:0]               reg_rdata,    // Read data.
  input  wire logic                      acc_req,      // Start an access.
  input  wire logic                      acc_write,    // Access is a write.
  input  wire logic                      mrs_req,      // Mode set request.
  output      logic                      acc_busy,     // Sequencer busy.
  output      logic                      acc_done,     // Access finished.
  output      logic                      rd_capture,   // Read data valid.
  output      logic                      mrs_refused,  // Mode set refused.
  output      sdram_cfg_pkg::sdram_cmd_t sdram_cmd     // Command to SDRAM.
);
  import sdram_cfg_pkg::*;

  // ==========================================================================
  // Sequencer state encoding.
  typedef enum logic [2:0] {
    ST_IDLE     = 3'b000,
    ST_ACTIVATE = 3'b001,
    ST_COLUMN   = 3'b010,
    ST_SUSPEND  = 3'b011,
    ST_DATA     = 3'b100,
    ST_WR_WAIT  = 3'b101,
    ST_PRECHG   = 3'b110,
    ST_MODE_SET = 3'b111
  } seq_state_t;

  logic [15:0] dram_enable_register;
  logic [15:0] sync_dram_control;
  logic [15:0] next_dram_enable_register;
  logic [15:0] next_sync_dram_control;
  logic [15:0] next_reg_rdata;
  logic        dram_type_select;

  seq_state_t  state;
  seq_state_t  next_state;
  logic        is_write;
  logic        next_is_write;
  sdram_cmd_t  next_sdram_cmd;
  logic        next_acc_done;
  logic        next_rd_capture;
  logic        next_mrs_refused;
  logic        capture;
  access_cfg_t snap;

  // Keeps only the bits that software may change in a register.
  function automatic logic [15:0] masked_write(input logic [15:0] data,
                                               input logic [15:0] mask);
    masked_write = data & mask;
  endfunction

  assign dram_type_select = dram_enable_register[DRAM_TYPE_SELECT_BIT];

  // ==========================================================================
  // Register file.

  // Computes register updates and the read answer for the next cycle.
  always_comb begin
    next_dram_enable_register = dram_enable_register;
    next_sync_dram_control    = sync_dram_control;
    next_reg_rdata            = '0;
    if (reg_write) begin
      unique case (reg_addr)
        DRAM_ENABLE_OFF: begin
          next_dram_enable_register = masked_write(reg_wdata,
                                                   DRAM_ENABLE_MASK);
        end
        SYNC_DRAM_CONTROL_OFF: begin
          // Bits 14 to 12, 9 and 6 to 1 drop writes; 11, 10, 8 are kept.
          next_sync_dram_control = masked_write(reg_wdata,
                                                SYNC_DRAM_CTRL_MASK);
        end
        default: begin
          next_sync_dram_control = sync_dram_control;
        end
      endcase
    end
    if (reg_read) begin
      unique case (reg_addr)
        DRAM_ENABLE_OFF:       next_reg_rdata = dram_enable_register;
        SYNC_DRAM_CONTROL_OFF: next_reg_rdata = sync_dram_control;
        SDRAM_STATUS_OFF: begin
          // Bits 7 to 5 settings, bits 3 to 1 state, bit 0 busy.
          next_reg_rdata = {8'h00, snap, 1'b0, state, acc_busy};
        end
        default:               next_reg_rdata = 16'h0000;
      endcase
    end
  end

  // Registers the control words and the read answer.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dram_enable_register <= DRAM_ENABLE_RESET;
      sync_dram_control    <= SYNC_DRAM_CTRL_RESET;
      reg_rdata            <= 16'h0000;
    end else begin
      dram_enable_register <= next_dram_enable_register;
      sync_dram_control    <= next_sync_dram_control;
      reg_rdata            <= next_reg_rdata;
    end
  end

  // ==========================================================================
  // Settings snapshot, taken as an access leaves idle.
  assign capture = (state == ST_IDLE) && (acc_req || mrs_req);

  access_snapshot u_snapshot (
    .sys_clk      (sys_clk),
    .reset        (reset),
    .capture      (capture),
    .sdram_select (dram_type_select),
    .ctrl_value   (sync_dram_control),
    .snap         (snap)
  );

  assign acc_busy = (state != ST_IDLE);

  // ==========================================================================
  // Access sequencer.

  // Chooses the next command; the snapshot is valid from ST_ACTIVATE on.
  always_comb begin
    next_state       = state;
    next_is_write    = is_write;
    next_sdram_cmd   = CMD_IDLE_BUS;
    next_acc_done    = 1'b0;
    next_rd_capture  = 1'b0;
    next_mrs_refused = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (mrs_req) begin
          next_state = ST_MODE_SET;
        end else if (acc_req) begin
          next_is_write = acc_write;
          next_state    = ST_ACTIVATE;
          next_sdram_cmd.code = CMD_ACTIVATE;
        end
      end
      ST_MODE_SET: begin
        if (snap.mode_reg_set_enable) begin
          next_sdram_cmd.code = CMD_MODE_SET;
          next_acc_done       = 1'b1;
        end else begin
          next_mrs_refused    = 1'b1;
        end
        next_state = ST_IDLE;
      end
      ST_ACTIVATE: begin
        next_sdram_cmd.code = is_write ? CMD_WRITE : CMD_READ;
        next_state          = ST_COLUMN;
      end
      ST_COLUMN: begin
        if (is_write) begin
          if (snap.write_precharge_delay) begin
            next_state = ST_WR_WAIT;
          end else begin
            next_sdram_cmd.code = CMD_PRECHARGE;
            next_state          = ST_PRECHG;
          end
        end else if (snap.clock_suspend_enable) begin
          next_sdram_cmd.cke = 1'b0;
          next_state         = ST_SUSPEND;
        end else begin
          next_rd_capture = 1'b1;
          next_state      = ST_DATA;
        end
      end
      ST_SUSPEND: begin
        // The clock is held one cycle so the read data stand longer.
        next_rd_capture = 1'b1;
        next_state      = ST_DATA;
      end
      ST_DATA: begin
        next_sdram_cmd.code = CMD_PRECHARGE;
        next_state          = ST_PRECHG;
      end
      ST_WR_WAIT: begin
        next_sdram_cmd.code = CMD_PRECHARGE;
        next_state          = ST_PRECHG;
      end
      ST_PRECHG: begin
        next_acc_done = 1'b1;
        next_state    = ST_IDLE;
      end
    endcase
  end

  // Registers sequencer state and every output toward the memory.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state       <= ST_IDLE;
      is_write    <= 1'b0;
      sdram_cmd   <= CMD_IDLE_BUS;
      acc_done    <= 1'b0;
      rd_capture  <= 1'b0;
      mrs_refused <= 1'b0;
    end else begin
      state       <= next_state;
      is_write    <= next_is_write;
      sdram_cmd   <= next_sdram_cmd;
      acc_done    <= next_acc_done;
      rd_capture  <= next_rd_capture;
      mrs_refused <= next_mrs_refused;
    end
  end

endmodule // sdram_ctrl_block

// file: testbench/sdram_ctrl_assertions.sv
// Port-level assertions for the synchronous DRAM control block.
`timescale 1ns/1ps
module sdram_ctrl_checker
  import sdram_cfg_pkg::*;
(
  input logic        sys_clk,     // Clock.
  input logic        reset,       // Reset.
  input logic [7:0]  reg_addr,    // Address.
  input logic        reg_read,    // Read strobe.
  input logic [15:0] reg_rdata,   // Read data.
  input logic        acc_req,     // Access request.
  input logic        acc_write,   // Write access.
  input logic        mrs_req,     // Mode set request.
  input logic        acc_busy,    // Busy.
  input logic        acc_done,    // Done pulse.
  input logic        rd_capture,  // Read data valid.
  input logic        mrs_refused, // Refused pulse.
  input sdram_cmd_t  sdram_cmd    // Command.
);
  // ==========
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // Accepted read and write requests.
  wire logic go = acc_req && !mrs_req && !acc_busy;
  property p_slot; !$past(reg_read) |-> reg_rdata == 16'h0000; endproperty
  a_slot: assert property (p_slot)
    else $error("stray read data");
  property p_rsv;
    $past(reg_read) && $past(reg_addr) == SYNC_DRAM_CONTROL_OFF
      |-> (reg_rdata & ~SYNC_DRAM_CTRL_MASK) == 16'h0000;
  endproperty
  a_rsv: assert property (p_rsv)
    else $error("reserved bits set");
  property p_rd; go && !acc_write |=> sdram_cmd.code == CMD_ACTIVATE
    ##1 sdram_cmd.code == CMD_READ; endproperty
  a_rd: assert property (p_rd)
    else $error("bad read start");
  property p_wr; go && acc_write |=> sdram_cmd.code == CMD_ACTIVATE
    ##1 sdram_cmd.code == CMD_WRITE; endproperty
  a_wr: assert property (p_wr)
    else $error("bad write start");
  property p_pre; sdram_cmd.code == CMD_WRITE
    |-> ##[1:2] sdram_cmd.code == CMD_PRECHARGE; endproperty
  a_pre: assert property (p_pre)
    else $error("no precharge after write");
  property p_susp; !sdram_cmd.cke |=> rd_capture; endproperty
  a_susp: assert property (p_susp)
    else $error("suspend not before capture");
  property p_cap; rd_capture |=> sdram_cmd.code == CMD_PRECHARGE
    ##1 acc_done; endproperty
  a_cap: assert property (p_cap)
    else $error("bad read end");
  property p_mrs; mrs_req && !acc_busy |-> ##2
    mrs_refused != (acc_done && sdram_cmd.code == CMD_MODE_SET); endproperty
  a_mrs: assert property (p_mrs)
    else $error("bad mode set outcome");
  property p_busy; (acc_req || mrs_req) && !acc_busy |=> acc_busy;
  endproperty
  a_busy: assert property (p_busy)
    else $error("request not taken");
  // Main scenarios seen.
  c_susp: cover property (!sdram_cmd.cke);
  c_refuse: cover property (mrs_refused);
  c_delay: cover property (sdram_cmd.code == CMD_WRITE ##2
    sdram_cmd.code == CMD_PRECHARGE);
endmodule // sdram_ctrl_checker

bind sdram_ctrl_block sdram_ctrl_checker u_chk (
  .sys_clk(sys_clk), .reset(reset), .reg_addr(reg_addr),
  .reg_read(reg_read), .reg_rdata(reg_rdata), .acc_req(acc_req),
  .acc_write(acc_write), .mrs_req(mrs_req), .acc_busy(acc_busy),
  .acc_done(acc_done), .rd_capture(rd_capture),
  .mrs_refused(mrs_refused), .sdram_cmd(sdram_cmd));

// file: testbench/sdram_interface_control_reg_test.sv
// Self-checking bench for the synchronous DRAM control block.
`timescale 1ns/1ps
module sdram_interface_control_reg_test;
  import sdram_cfg_pkg::*;
  // Per-cycle traces {done, capture, refused, cke, code}, first cycle low.
  localparam logic [63:0] T_RD = 64'h1717179712571513;
  localparam logic [63:0] T_RS = 64'h1717971257071513;
  localparam logic [63:0] T_WR = 64'h1717171797121413;
  localparam logic [63:0] T_WD = 64'h1717179712171413;
  localparam logic [63:0] T_MS = 64'h1717171717179017;
  localparam logic [63:0] T_MR = 64'h1717171717173717;
  logic        sys_clk = 1'b0;
  logic        reset = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_write = 1'b0;
  logic        reg_read = 1'b0;
  logic        acc_req = 1'b0;
  logic        acc_write = 1'b0;
  logic        mrs_req = 1'b0;
  logic [15:0] reg_rdata;
  logic        acc_busy, acc_done, rd_capture, mrs_refused, model_err;
  sdram_cmd_t  sdram_cmd;
  int          n_mismatch = 0;
  int          checks = 0;

  sdram_ctrl_block dut (.sys_clk(sys_clk), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .acc_req(acc_req),
    .acc_write(acc_write), .mrs_req(mrs_req), .acc_busy(acc_busy),
    .acc_done(acc_done), .rd_capture(rd_capture),
    .mrs_refused(mrs_refused), .sdram_cmd(sdram_cmd));
  sdram_model mem (.sys_clk(sys_clk), .reset(reset),
    .sdram_cmd(sdram_cmd), .model_err(model_err));

  // Clock of 100 ns period.
  initial begin
    forever #50 sys_clk = ~sys_clk;
  end

  task automatic end_sim();
    $display("mismatches %0d checks %0d", n_mismatch, checks);
    if (n_mismatch == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_write <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_write <= 1'b0;
  endtask

  task automatic reg_rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_read <= 1'b0;
    @(negedge sys_clk);
    chk(reg_rdata, e);
  endtask

  // One request, then eight cycles compared against a trace.
  task automatic acc(input logic wr, mrs, input logic [63:0] t);
    @(posedge sys_clk);
    acc_req   <= ~mrs;
    mrs_req   <= mrs;
    acc_write <= wr;
    @(posedge sys_clk);
    acc_req <= 1'b0;
    mrs_req <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      @(negedge sys_clk);
      chk({8'h00, acc_done, rd_capture, mrs_refused, sdram_cmd},
          {8'h00, t[k*8 +: 8]});
    end
  endtask

  task automatic t_regs();
    reg_rd(8'h04, 16'h0000);
    reg_wr(8'h04, 16'hFFFF);
    reg_rd(8'h04, 16'h8D81);
    reg_rd(8'h0C, 16'h0000);
  endtask

  task automatic t_type_off();
    acc(1'b0, 1'b0, T_RD);
    acc(1'b1, 1'b0, T_WR);
    acc(1'b0, 1'b1, T_MR);
    reg_rd(8'h08, 16'h0000);
    reg_wr(8'h04, 16'h0000);
    reg_wr(8'h00, 16'hFFFF);
    reg_rd(8'h00, 16'h0001);
  endtask

  task automatic t_access();
    acc(1'b0, 1'b0, T_RD);
    acc(1'b1, 1'b0, T_WR);
    acc(1'b0, 1'b1, T_MR);
    reg_wr(8'h04, 16'h8081);
    acc(1'b0, 1'b0, T_RS);
    acc(1'b1, 1'b0, T_WD);
    acc(1'b0, 1'b1, T_MS);
    reg_rd(8'h08, 16'h00E0);
  endtask

  task automatic t_snapshot();
    reg_wr(8'h04, 16'h0000);
    fork
      acc(1'b0, 1'b0, T_RD);
      begin
        repeat (2) @(posedge sys_clk);
        reg_wr(8'h04, 16'h0080);
      end
    join
    acc(1'b0, 1'b0, T_RS);
    reg_wr(8'h04, 16'h0000);
    chk({15'h0000, model_err}, 16'h0000);
  endtask

  // Hang guard.
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    $display("unexpected at %0t: timeout", $time);
    end_sim();
  end

  // Main sequence.
  initial begin
    repeat (12) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs();
    t_type_off();
    t_access();
    t_snapshot();
    end_sim();
  end
endmodule // sdram_interface_control_reg_test

// file: testbench/sdram_model.sv
// Behavioural synchronous DRAM that flags commands given out of order.
`timescale 1ns/1ps
module sdram_model
  import sdram_cfg_pkg::*;
(
  input  logic       sys_clk,   // Clock.
  input  logic       reset,     // Reset.
  input  sdram_cmd_t sdram_cmd, // Command in.
  output logic       model_err  // Sticky error.
);
  logic row_open;
  // Track the open row; access or suspend without one is an error.
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      row_open  <= 1'b0;
      model_err <= 1'b0;
    end else if (!sdram_cmd.cke) begin
      model_err <= model_err | !row_open;
    end else begin
      case (sdram_cmd.code)
        CMD_ACTIVATE: begin
          model_err <= model_err | row_open;
          row_open  <= 1'b1;
        end
        CMD_READ, CMD_WRITE: model_err <= model_err | !row_open;
        CMD_PRECHARGE: row_open <= 1'b0;
        CMD_MODE_SET: model_err <= model_err | row_open;
        default: ;
      endcase
    end
  end
endmodule // sdram_model
